// ---- design/cbe_bytemem.sv ----
/*
 * Sixteen-byte memory with per-byte fill tracking and XOR load.
 * Assumes writes arrive as one 32-bit word with byte strobes.
 */
`timescale 1ns/1ps
`default_nettype none
module cbe_bytemem #(
    parameter int NB = 16
) (
    input  wire logic              aclk,
    input  wire logic              aresetn,
    input  wire cbe_pkg::cbe_wr_t  wr,
    input  wire logic              xor_en,
    input  wire logic              load,
    input  wire logic [NB*8-1:0]   ldata,
    input  wire logic              clr_fill,
    output logic      [NB*8-1:0]   data,
    output logic                   full
);
    typedef struct packed {
        logic [NB-1:0][7:0] mem;
        logic [NB-1:0]      fill;
    } cbe_mem_t;

    cbe_mem_t s_ff;
    cbe_mem_t nxt_s;

    always_comb begin
        nxt_s = s_ff;
        if (clr_fill) begin
            nxt_s.fill = '0;
        end
        if (load) begin
            nxt_s.mem = ldata;
        end
        for (int i = 0; i < NB; i++) begin
            if (wr.we && wr.idx == 2'(i / 4) && wr.strb[i % 4]) begin
                // XOR mode folds new byte into old
                nxt_s.mem[i]  = xor_en ? (s_ff.mem[i] ^ wr.data[8*(i%4) +: 8])
                                       : wr.data[8*(i%4) +: 8]; // [RULE_07]
                nxt_s.fill[i] = 1'b1;
            end
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            s_ff <= '0;
        end else begin
            s_ff <= nxt_s;
        end
    end

    assign data = s_ff.mem;
    assign full = &s_ff.fill;
endmodule
`default_nettype wire

// ---- design/cbe_core.sv ----
/*
 * Iterative 128-bit block cipher datapath, one round per cycle.
 * Assumes key and input stay stable from start until done.
 */
`timescale 1ns/1ps
`default_nettype none
module cbe_core #(
    parameter int unsigned ROUNDS = cbe_pkg::ROUNDS
) (
    input  wire logic                      aclk,
    input  wire logic                      aresetn,
    input  wire logic                      start,
    input  wire logic                      decrypt,
    input  wire logic [cbe_pkg::BLK_W-1:0] key,
    input  wire logic [cbe_pkg::BLK_W-1:0] din,
    output logic      [cbe_pkg::BLK_W-1:0] dout,
    output logic                           done
);
    localparam int unsigned BW = cbe_pkg::BLK_W;
    localparam int unsigned RW = cbe_pkg::RND_W;
    localparam logic [RW-1:0] R_LAST = RW'(ROUNDS - 1);

    typedef struct packed {
        logic [BW-1:0] s;
        logic [RW-1:0] r;
        logic          run;
        logic          dir;
        logic          done;
    } cbe_core_t;

    cbe_core_t s_ff;
    cbe_core_t nxt_s;

    function automatic logic [BW-1:0] rkey(input logic [BW-1:0] k, input logic [RW-1:0] r);
        logic [2*BW-1:0] d;
        d = {k, k} << {r, 3'b000};
        return d[2*BW-1:BW] ^ BW'(r);
    endfunction

    function automatic logic [BW-1:0] lanes(input logic [BW-1:0] a, input logic [BW-1:0] b,
                                            input logic sub);
        logic [BW-1:0] o;
        o = '0;
        for (int j = 0; j < BW / 32; j++) begin
            o[32*j +: 32] = sub ? a[32*j +: 32] - b[32*j +: 32] : a[32*j +: 32] + b[32*j +: 32];
        end
        return o;
    endfunction

    logic [BW-1:0] rk;
    logic [BW-1:0] t;

    always_comb begin
        nxt_s = s_ff;
        rk    = rkey(key, s_ff.r);
        t     = s_ff.s ^ rk;
        if (start) begin
            nxt_s.s    = din;
            nxt_s.r    = decrypt ? R_LAST : '0;
            nxt_s.run  = 1'b1;
            nxt_s.dir  = decrypt;
            nxt_s.done = 1'b0;
        end else if (s_ff.run) begin
            // Decrypt undoes the encrypt rounds in reverse order
            if (s_ff.dir) begin
                t       = lanes(s_ff.s, rk, 1'b1);
                nxt_s.s = ((t >> cbe_pkg::ROT) | (t << (BW - cbe_pkg::ROT))) ^ rk; // [RULE_01]
                nxt_s.r = s_ff.r - 1'b1;
            end else begin
                nxt_s.s = lanes((t << cbe_pkg::ROT) | (t >> (BW - cbe_pkg::ROT)), rk, 1'b0);
                nxt_s.r = s_ff.r + 1'b1;
            end
            if (s_ff.r == (s_ff.dir ? '0 : R_LAST)) begin
                nxt_s.run  = 1'b0;
                nxt_s.done = 1'b1;
            end
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            s_ff <= '0;
        end else begin
            s_ff <= nxt_s;
        end
    end

    assign dout = s_ff.s;
    assign done = s_ff.done;
endmodule
`default_nettype wire

// ---- design/cbe_pkg.sv ----
/*
 * Constants, types and register map of the block cipher engine.
 * Assumes a 32-bit AXI4-Lite slave with 8 decoded address bits.
 */
`default_nettype none
package cbe_pkg;
    localparam int unsigned DATA_W = 32;
    localparam int unsigned ADDR_W = 8;
    localparam int unsigned BLK_W  = 128;
    localparam int unsigned NBYTES = 16;

    localparam logic [7:0] OFF_CTRL   = 8'h00;
    localparam logic [7:0] OFF_STATUS = 8'h04;
    localparam logic [7:0] OFF_MASK   = 8'h08;
    localparam logic [3:0] WIN_KEY    = 4'h1;
    localparam logic [3:0] WIN_STATE  = 4'h2;

    localparam int CTRL_START   = 0;
    localparam int CTRL_DECRYPT = 1;
    localparam int CTRL_AUTO    = 2;
    localparam int CTRL_XOR     = 3;
    localparam int ST_DONE      = 0;
    localparam int ST_BUSY      = 1;

    localparam int unsigned OP_CYCLES = 375;
    localparam int unsigned CNT_W     = 9;
    localparam logic [CNT_W-1:0] OP_LAST = CNT_W'(OP_CYCLES - 1);
    localparam int unsigned ROUNDS    = 10;
    localparam int unsigned RND_W     = 4;
    localparam int unsigned ROT       = 13;

    localparam logic [1:0] RESP_OKAY   = 2'b00;
    localparam logic [1:0] RESP_DECERR = 2'b11;

    typedef enum logic [1:0] {
        CBE_IDLE = 2'b00,
        CBE_RUN  = 2'b01
    } cbe_fsm_t;

    typedef struct packed {
        logic xor_mode;
        logic auto_start;
        logic decrypt;
    } cbe_ctrl_t;

    typedef struct packed {
        logic        we;
        logic [1:0]  idx;
        logic [3:0]  strb;
        logic [31:0] data;
    } cbe_wr_t;
endpackage
`default_nettype wire

// ---- design/cbe_top.sv ----
/*
 * Block cipher engine: AXI4-Lite registers, key and state memories,
 * fixed-length operation sequencing, done interrupt and DMA trigger.
 * Assumes a single 200 MHz clock and a synchronous active-low reset.
 */
// Local design decisions: the register offsets and the AXI4-Lite interface to the registers.
`timescale 1ns/1ps
`default_nettype none
// Behaviour
// RULE_01: Encrypt or decrypt 128-bit block, 128-bit key
// RULE_02: Master loads key and state before start
// RULE_03: Done 375 cycles after start, result readable
// RULE_04: Completion makes data readable, optional interrupt
// RULE_05: DMA trigger pulse on every completion
// RULE_06: Auto-start once all sixteen state bytes written
// RULE_07: XOR mode folds writes into state bytes
// RULE_08: Done flag set, cleared; start ignored when busy
module cbe_top (
    input  wire logic        aclk,
    input  wire logic        aresetn,
    input  wire logic [7:0]  s_axi_awaddr,
    input  wire logic        s_axi_awvalid,
    output logic             s_axi_awready,
    input  wire logic [31:0] s_axi_wdata,
    input  wire logic [3:0]  s_axi_wstrb,
    input  wire logic        s_axi_wvalid,
    output logic             s_axi_wready,
    output logic [1:0]       s_axi_bresp,
    output logic             s_axi_bvalid,
    input  wire logic        s_axi_bready,
    input  wire logic [7:0]  s_axi_araddr,
    input  wire logic        s_axi_arvalid,
    output logic             s_axi_arready,
    output logic [31:0]      s_axi_rdata,
    output logic [1:0]       s_axi_rresp,
    output logic             s_axi_rvalid,
    input  wire logic        s_axi_rready,
    output logic             irq,
    output logic             dma_trig
);
    localparam int unsigned BW = cbe_pkg::BLK_W;

    typedef struct packed {
        cbe_pkg::cbe_fsm_t          fsm;
        logic [cbe_pkg::CNT_W-1:0]  cnt;
        cbe_pkg::cbe_ctrl_t         ctrl;
        logic                       done;
        logic                       mask;
        logic                       irq;
        logic                       dma;
        logic                       aw_held;
        logic [7:0]                 awaddr;
        logic                       aw_rdy;
        logic                       w_held;
        logic [31:0]                wdata;
        logic [3:0]                 wstrb;
        logic                       w_rdy;
        logic                       bvalid;
        logic [1:0]                 bresp;
        logic                       ar_rdy;
        logic                       rvalid;
        logic [31:0]                rdata;
        logic [1:0]                 rresp;
    } cbe_top_t;

    cbe_top_t s_ff;
    cbe_top_t nxt_s;

    logic              do_wr;
    logic              do_rd;
    logic              idle;
    logic              start_go;
    logic              go_dec;
    logic              auto_go;
    logic              finish;
    logic              wr_ok;
    cbe_pkg::cbe_wr_t  key_wr;
    cbe_pkg::cbe_wr_t  st_wr;
    logic [BW-1:0]     key_data;
    logic [BW-1:0]     st_data;
    logic [BW-1:0]     core_dout;
    logic              core_done;
    logic              st_full;

    cbe_bytemem #(
        .NB       (cbe_pkg::NBYTES)
    ) u_key_mem (
        .aclk     (aclk),
        .aresetn  (aresetn),
        .wr       (key_wr),
        .xor_en   (1'b0),
        .load     (1'b0),
        .ldata    ('0),
        .clr_fill (1'b0),
        .data     (key_data),
        .full     ()
    );

    cbe_bytemem #(
        .NB       (cbe_pkg::NBYTES)
    ) u_state_mem (
        .aclk     (aclk),
        .aresetn  (aresetn),
        .wr       (st_wr),
        .xor_en   (s_ff.ctrl.xor_mode),
        .load     (finish),
        .ldata    (core_dout),
        .clr_fill (start_go),
        .data     (st_data),
        .full     (st_full)
    );

    cbe_core #(
        .ROUNDS   (cbe_pkg::ROUNDS)
    ) u_core (
        .aclk     (aclk),
        .aresetn  (aresetn),
        .start    (start_go),
        .decrypt  (go_dec),
        .key      (key_data),
        .din      (st_data),
        .dout     (core_dout),
        .done     (core_done)
    );

    always_comb begin
        idle     = (s_ff.fsm == cbe_pkg::CBE_IDLE);
        do_wr    = s_ff.aw_held && s_ff.w_held && !s_ff.bvalid;
        do_rd    = s_ff.ar_rdy && s_axi_arvalid;
        auto_go  = idle && s_ff.ctrl.auto_start && st_full; // [RULE_06]
        // Start written with its direction bit runs in that direction
        go_dec   = auto_go ? s_ff.ctrl.decrypt : s_ff.wdata[cbe_pkg::CTRL_DECRYPT]; // [RULE_01]
        // Start command while busy is dropped
        start_go = auto_go || (idle && do_wr && s_ff.awaddr == cbe_pkg::OFF_CTRL
                               && s_ff.wstrb[0] && s_ff.wdata[cbe_pkg::CTRL_START]); // [RULE_08]
        finish   = (s_ff.fsm == cbe_pkg::CBE_RUN) && s_ff.cnt == cbe_pkg::OP_LAST; // [RULE_03]
        // Memories frozen while an operation is pending or running
        wr_ok    = idle && !auto_go;
        key_wr.we   = do_wr && wr_ok && s_ff.awaddr[7:4] == cbe_pkg::WIN_KEY;
        key_wr.idx  = s_ff.awaddr[3:2];
        key_wr.strb = s_ff.wstrb;
        key_wr.data = s_ff.wdata;
        st_wr       = key_wr;
        st_wr.we    = do_wr && wr_ok && s_ff.awaddr[7:4] == cbe_pkg::WIN_STATE;
    end

    always_comb begin
        nxt_s     = s_ff;
        nxt_s.dma = 1'b0;
        // Operation sequencing
        case (s_ff.fsm)
            cbe_pkg::CBE_IDLE: begin
                if (start_go) begin
                    nxt_s.fsm  = cbe_pkg::CBE_RUN;
                    nxt_s.cnt  = '0;
                    nxt_s.done = 1'b0; // [RULE_08]
                end
            end
            cbe_pkg::CBE_RUN: begin
                nxt_s.cnt = s_ff.cnt + 1'b1;
                if (finish) begin
                    nxt_s.fsm = cbe_pkg::CBE_IDLE;
                    nxt_s.dma = 1'b1; // [RULE_05]
                end
            end
            default: begin
                nxt_s.fsm = cbe_pkg::CBE_IDLE;
            end
        endcase
        // Write address and data channels
        if (s_ff.aw_rdy && s_axi_awvalid) begin
            nxt_s.aw_held = 1'b1;
            nxt_s.awaddr  = s_axi_awaddr;
        end
        if (s_ff.w_rdy && s_axi_wvalid) begin
            nxt_s.w_held = 1'b1;
            nxt_s.wdata  = s_axi_wdata;
            nxt_s.wstrb  = s_axi_wstrb;
        end
        if (do_wr) begin
            nxt_s.aw_held = 1'b0;
            nxt_s.w_held  = 1'b0;
            nxt_s.bvalid  = 1'b1;
            nxt_s.bresp   = cbe_pkg::RESP_OKAY;
            if (s_ff.awaddr == cbe_pkg::OFF_CTRL) begin
                if (s_ff.wstrb[0] && idle) begin
                    nxt_s.ctrl.decrypt    = s_ff.wdata[cbe_pkg::CTRL_DECRYPT];
                    nxt_s.ctrl.auto_start = s_ff.wdata[cbe_pkg::CTRL_AUTO];
                    nxt_s.ctrl.xor_mode   = s_ff.wdata[cbe_pkg::CTRL_XOR];
                end
            end else if (s_ff.awaddr == cbe_pkg::OFF_STATUS) begin
                // Completion in the same cycle keeps the flag set
                if (s_ff.wstrb[0] && s_ff.wdata[cbe_pkg::ST_DONE] && !start_go) begin
                    nxt_s.done = 1'b0; // [RULE_08]
                end
            end else if (s_ff.awaddr == cbe_pkg::OFF_MASK) begin
                if (s_ff.wstrb[0]) begin
                    nxt_s.mask = s_ff.wdata[cbe_pkg::ST_DONE];
                end
            end else if (s_ff.awaddr[7:4] == cbe_pkg::WIN_KEY
                         || s_ff.awaddr[7:4] == cbe_pkg::WIN_STATE) begin
                nxt_s.bresp = cbe_pkg::RESP_OKAY;
            end else begin
                nxt_s.bresp = cbe_pkg::RESP_DECERR;
            end
        end
        if (finish) begin
            nxt_s.done = 1'b1; // [RULE_04]
        end
        if (s_ff.bvalid && s_axi_bready) begin
            nxt_s.bvalid = 1'b0;
        end
        // Read channel
        if (s_ff.rvalid && s_axi_rready) begin
            nxt_s.rvalid = 1'b0;
        end
        if (do_rd) begin
            nxt_s.rvalid = 1'b1;
            nxt_s.rresp  = cbe_pkg::RESP_OKAY;
            nxt_s.rdata  = '0;
            if (s_axi_araddr == cbe_pkg::OFF_CTRL) begin
                nxt_s.rdata[cbe_pkg::CTRL_DECRYPT] = s_ff.ctrl.decrypt;
                nxt_s.rdata[cbe_pkg::CTRL_AUTO]    = s_ff.ctrl.auto_start;
                nxt_s.rdata[cbe_pkg::CTRL_XOR]     = s_ff.ctrl.xor_mode;
            end else if (s_axi_araddr == cbe_pkg::OFF_STATUS) begin
                nxt_s.rdata[cbe_pkg::ST_DONE] = s_ff.done;
                nxt_s.rdata[cbe_pkg::ST_BUSY] = !idle;
            end else if (s_axi_araddr == cbe_pkg::OFF_MASK) begin
                nxt_s.rdata[cbe_pkg::ST_DONE] = s_ff.mask;
            end else if (s_axi_araddr[7:4] == cbe_pkg::WIN_STATE) begin
                nxt_s.rdata = st_data[32*s_axi_araddr[3:2] +: 32]; // [RULE_04]
            end else if (s_axi_araddr[7:4] == cbe_pkg::WIN_KEY) begin
                nxt_s.rdata = '0;
            end else begin
                nxt_s.rresp = cbe_pkg::RESP_DECERR;
            end
        end
        nxt_s.aw_rdy = !nxt_s.aw_held && !nxt_s.bvalid;
        nxt_s.w_rdy  = !nxt_s.w_held && !nxt_s.bvalid;
        nxt_s.ar_rdy = !nxt_s.rvalid;
        nxt_s.irq    = nxt_s.done && nxt_s.mask; // [RULE_04]
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            s_ff <= '0;
        end else begin
            s_ff <= nxt_s;
        end
    end

    assign s_axi_awready = s_ff.aw_rdy;
    assign s_axi_wready  = s_ff.w_rdy;
    assign s_axi_bvalid  = s_ff.bvalid;
    assign s_axi_bresp   = s_ff.bresp;
    assign s_axi_arready = s_ff.ar_rdy;
    assign s_axi_rvalid  = s_ff.rvalid;
    assign s_axi_rdata   = s_ff.rdata;
    assign s_axi_rresp   = s_ff.rresp;
    assign irq           = s_ff.irq;
    assign dma_trig      = s_ff.dma;

    // Cycles since the last accepted start, saturating
    logic [9:0] age_ff;
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            age_ff <= '1;
        end else if (start_go) begin
            age_ff <= '0;
        end else if (age_ff != '1) begin
            age_ff <= age_ff + 1'b1;
        end
    end

    op_length_a: assert property ( // [RULE_03]
        @(posedge aclk) disable iff (!aresetn)
        $rose(s_ff.done) |-> age_ff == 10'(cbe_pkg::OP_CYCLES))
        else $error("done not 375 cycles after start");

    done_clear_a: assert property ( // [RULE_08]
        @(posedge aclk) disable iff (!aresetn)
        start_go |=> !s_ff.done && s_ff.fsm == cbe_pkg::CBE_RUN)
        else $error("start did not clear done or set busy");

    busy_ignore_a: assert property ( // [RULE_08]
        @(posedge aclk) disable iff (!aresetn)
        s_ff.fsm == cbe_pkg::CBE_RUN && !finish
        |=> s_ff.fsm == cbe_pkg::CBE_RUN && s_ff.cnt == $past(s_ff.cnt) + 1'b1
            && s_ff.ctrl == $past(s_ff.ctrl))
        else $error("running count disturbed");

    dma_pulse_a: assert property ( // [RULE_05]
        @(posedge aclk) disable iff (!aresetn)
        $rose(s_ff.done) |-> dma_trig ##1 !dma_trig)
        else $error("dma trigger not a one-cycle pulse at completion");

    irq_gate_a: assert property ( // [RULE_04]
        @(posedge aclk) disable iff (!aresetn)
        irq == (s_ff.done && s_ff.mask))
        else $error("interrupt does not follow done and mask");

    auto_start_a: assert property ( // [RULE_06]
        @(posedge aclk) disable iff (!aresetn)
        idle && s_ff.ctrl.auto_start && st_full |=> s_ff.fsm == cbe_pkg::CBE_RUN ##1 !st_full)
        else $error("full state did not auto-start");

    xor_load_a: assert property ( // [RULE_07]
        @(posedge aclk) disable iff (!aresetn)
        st_wr.we && st_wr.idx == 2'b00 && st_wr.strb[0] && s_ff.ctrl.xor_mode
        |=> st_data[7:0] == ($past(st_data[7:0]) ^ $past(st_wr.data[7:0])))
        else $error("xor load result wrong");

    result_load_a: assert property ( // [RULE_01]
        @(posedge aclk) disable iff (!aresetn)
        finish |-> $past(core_done, 2) ##1 st_data == $past(core_dout))
        else $error("result not in state memory at done");
endmodule
`default_nettype wire

// ---- dv/block_cipher_engine_bench.sv ----
/*
 * Self-checking bench of the block cipher engine over AXI4-Lite.
 * Assumes the cbe_axi_master model and a 200 MHz clock.
 */
`timescale 1ns/1ps
`default_nettype none
module block_cipher_engine_bench;
    localparam logic [7:0]  CT  = cbe_pkg::OFF_CTRL;
    localparam logic [7:0]  ST  = cbe_pkg::OFF_STATUS;
    localparam logic [7:0]  MK  = cbe_pkg::OFF_MASK;
    localparam logic [31:0] GO  = 32'h1 << cbe_pkg::CTRL_START;
    localparam logic [31:0] DEC = 32'h1 << cbe_pkg::CTRL_DECRYPT;
    localparam logic [31:0] AXM = (32'h1 << cbe_pkg::CTRL_AUTO) | (32'h1 << cbe_pkg::CTRL_XOR);
    localparam logic [31:0] BSY = 32'h1 << cbe_pkg::ST_BUSY;
    localparam logic [31:0] DN  = 32'h1 << cbe_pkg::ST_DONE;

    logic        aclk, aresetn, awvalid, awready, wvalid, wready, bvalid, bready;
    logic        arvalid, arready, rvalid, rready, irq, dma_trig, ch;
    logic [7:0]  awaddr, araddr;
    logic [31:0] wdata, rdata, d;
    logic [3:0]  wstrb;
    logic [1:0]  bresp, rresp, r;
    int          fails, n_tests, n_dma, cyc, t_done, t_start;
    logic [31:0] key[4] = '{32'h0f1e2d3c, 32'h4b5a6978, 32'h8796a5b4, 32'hc3d2e1f0};
    logic [31:0] pt[4]  = '{32'h00112233, 32'h44556677, 32'h8899aabb, 32'hccddeeff};
    logic [31:0] xm[4]  = '{32'ha5a5a5a5, 32'h5a5a5a5a, 32'h01020304, 32'hf0e0d0c0};
    logic [31:0] sv[4];

    initial aclk = 1'b0;
    always #2.5 aclk = ~aclk;

    cbe_top i_cbe_top (
        .aclk(aclk), .aresetn(aresetn),
        .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awready),
        .s_axi_wdata(wdata), .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid),
        .s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid),
        .s_axi_bready(bready), .s_axi_araddr(araddr), .s_axi_arvalid(arvalid),
        .s_axi_arready(arready), .s_axi_rdata(rdata), .s_axi_rresp(rresp),
        .s_axi_rvalid(rvalid), .s_axi_rready(rready), .irq(irq), .dma_trig(dma_trig)
    );

    cbe_axi_master i_cbe_axi_master (
        .aclk(aclk), .awaddr(awaddr), .awvalid(awvalid), .awready(awready),
        .wdata(wdata), .wstrb(wstrb), .wvalid(wvalid), .wready(wready),
        .bresp(bresp), .bvalid(bvalid), .bready(bready), .araddr(araddr),
        .arvalid(arvalid), .arready(arready), .rdata(rdata), .rresp(rresp),
        .rvalid(rvalid), .rready(rready)
    );

    // Counts trigger samples and notes when the last one came
    always @(posedge aclk) begin
        cyc <= cyc + 1;
        if (dma_trig === 1'b1) begin
            n_dma  <= n_dma + 1;
            t_done <= cyc;
        end
    end

    task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
        n_tests++;
        if (g !== e) begin
            fails++;
            $display("MISMATCH %s expected %h seen %h", nm, e, g);
        end
    endtask

    task automatic wr(input logic [7:0] a, input logic [31:0] v, input logic [3:0] s = 4'hf,
                      input logic [1:0] er = cbe_pkg::RESP_OKAY);
        i_cbe_axi_master.write(a, v, s, r);
        chk("bresp", {30'h0, er}, {30'h0, r});
    endtask

    task automatic rd(input logic [7:0] a, input logic [31:0] e, input bit ck = 1'b1,
                      input logic [1:0] er = cbe_pkg::RESP_OKAY);
        i_cbe_axi_master.read(a, d, r);
        chk("rresp", {30'h0, er}, {30'h0, r});
        if (ck) chk("rdata", e, d);
    endtask

    task automatic wait_done;
        int n;
        n = n_dma;
        while (n_dma == n) @(posedge aclk);
    endtask

    task automatic end_sim;
        $display("comparisons %0d mismatches %0d", n_tests, fails);
        if (fails == 0 && n_tests > 0) begin
            $display("ALL TESTS PASSED");
        end else begin
            $display("TESTS FAILED");
        end
        $finish;
    endtask

    initial begin
        aresetn = 1'b0;
        repeat (5) @(posedge aclk);
        aresetn <= 1'b1;
        chk("irq", 32'h0, {31'h0, irq});
        rd(ST, 32'h0);
        rd(MK, 32'h0);
        wr(8'h40, 32'h1, 4'hf, cbe_pkg::RESP_DECERR);
        rd(8'hf0, 32'h0, 1'b0, cbe_pkg::RESP_DECERR);
        for (int i = 0; i < 4; i++) begin
            wr(8'h10 + 8'(4 * i), key[i]);
            wr(8'h20 + 8'(4 * i), pt[i]);
        end
        rd(8'h10, 32'h0);
        wr(MK, DN);
        wr(CT, GO);
        t_start = cyc;
        rd(ST, BSY);
        wr(CT, GO | DEC);
        wr(8'h10, 32'h13572468);
        wait_done;
        chk("op_cycles", cbe_pkg::OP_CYCLES, t_done - t_start);
        chk("irq", 32'h1, {31'h0, irq});
        rd(ST, DN);
        ch = 1'b0;
        for (int i = 0; i < 4; i++) begin
            rd(8'h20 + 8'(4 * i), 32'h0, 1'b0);
            ch = ch | (d !== pt[i]);
        end
        chk("changed", 32'h1, {31'h0, ch});
        wr(CT, GO | DEC);
        wait_done;
        for (int i = 0; i < 4; i++) begin
            rd(8'h20 + 8'(4 * i), pt[i]);
        end
        wr(ST, DN);
        rd(ST, 32'h0);
        chk("irq", 32'h0, {31'h0, irq});
        wr(MK, 32'h0);
        wr(CT, GO);
        wait_done;
        chk("irq", 32'h0, {31'h0, irq});
        wr(MK, DN);
        rd(ST, DN);
        chk("irq", 32'h1, {31'h0, irq});
        for (int i = 0; i < 4; i++) begin
            rd(8'h20 + 8'(4 * i), 32'h0, 1'b0);
            sv[i] = d;
        end
        wr(CT, AXM);
        for (int i = 0; i < 3; i++) begin
            wr(8'h20 + 8'(4 * i), xm[i]);
        end
        wr(8'h2c, xm[3], 4'h7);
        rd(ST, DN);
        rd(8'h20, sv[0] ^ xm[0]);
        rd(8'h2c, {sv[3][31:24], sv[3][23:0] ^ xm[3][23:0]});
        wr(8'h2c, xm[3], 4'h8);
        rd(ST, BSY);
        wait_done;
        wr(CT, GO | DEC);
        wait_done;
        for (int i = 0; i < 4; i++) begin
            rd(8'h20 + 8'(4 * i), sv[i] ^ xm[i]);
        end
        chk("dma_pulses", 32'h5, n_dma);
        end_sim;
    end

    // Five operations and their bus traffic fit well inside this span
    initial begin
        repeat (20000) @(posedge aclk);
        fails++;
        end_sim;
    end
endmodule
`default_nettype wire

// ---- dv/cbe_axi_master.sv ----
/*
 * AXI4-Lite master model standing in for the CPU or DMA controller.
 * Assumes its tasks are called one at a time from the bench.
 */
`timescale 1ns/1ps
`default_nettype none
module cbe_axi_master (
    input  wire logic        aclk,
    output logic      [7:0]  awaddr,
    output logic             awvalid,
    input  wire logic        awready,
    output logic      [31:0] wdata,
    output logic      [3:0]  wstrb,
    output logic             wvalid,
    input  wire logic        wready,
    input  wire logic [1:0]  bresp,
    input  wire logic        bvalid,
    output logic             bready,
    output logic      [7:0]  araddr,
    output logic             arvalid,
    input  wire logic        arready,
    input  wire logic [31:0] rdata,
    input  wire logic [1:0]  rresp,
    input  wire logic        rvalid,
    output logic             rready
);
    initial begin
        awaddr  = 8'h00;
        awvalid = 1'b0;
        wdata   = 32'h0;
        wstrb   = 4'h0;
        wvalid  = 1'b0;
        bready  = 1'b0;
        araddr  = 8'h00;
        arvalid = 1'b0;
        rready  = 1'b0;
    end

    // Released payload shows the inverse, never the stale value
    task automatic write(input logic [7:0] a, input logic [31:0] v,
                         input logic [3:0] s, output logic [1:0] r);
        @(posedge aclk);
        awaddr  <= a;
        wdata   <= v;
        wstrb   <= s;
        awvalid <= 1'b1;
        wvalid  <= 1'b1;
        bready  <= 1'b1;
        forever begin
            @(posedge aclk);
            if (awvalid && awready) begin
                awvalid <= 1'b0;
                awaddr  <= ~a;
            end
            if (wvalid && wready) begin
                wvalid <= 1'b0;
                wdata  <= ~v;
            end
            if (bready && bvalid) begin
                r = bresp;
                bready <= 1'b0;
                break;
            end
        end
    endtask

    task automatic read(input logic [7:0] a, output logic [31:0] v,
                        output logic [1:0] r);
        @(posedge aclk);
        araddr  <= a;
        arvalid <= 1'b1;
        rready  <= 1'b1;
        forever begin
            @(posedge aclk);
            if (arvalid && arready) begin
                arvalid <= 1'b0;
                araddr  <= ~a;
            end
            if (rready && rvalid) begin
                v = rdata;
                r = rresp;
                rready <= 1'b0;
                break;
            end
        end
    endtask
endmodule
`default_nettype wire
